// ===== logic/odt_top.sv
// Output delay timers and update pacing for a level sensor
`timescale 1ns/10ps
`default_nettype none
module odt_top #(
  parameter int unsigned TICK_CYC = odt_pkg::TICK_CYC
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Configuration load
  input wire logic cfg_wr,
  input wire odt_pkg::odt_cfg_t cfg_in,
  // Measurement conditions
  input wire logic [odt_pkg::N_SW-1:0] sw_on_cond,
  input wire logic [odt_pkg::N_SW-1:0] sw_off_cond,
  input wire logic target_lost,
  input wire logic target_stable,
  // Switch and analog outputs
  output logic [odt_pkg::N_SW-1:0] sw_out_r,
  output odt_pkg::odt_ana_t loop_mode_r,
  output odt_pkg::odt_ana_t volt_mode_r,
  // Pacing and status
  output logic meas_tick_r,
  output logic upd_r,
  output logic temp_comp_r,
  output odt_pkg::odt_cfg_t cfg_r
);
  // ----------------------------------------------------------------
  // Configuration and 5 ms timebase
  // ----------------------------------------------------------------
  logic [17:0] div_r;
  logic tick_r;
  wire div_end = div_r == 18'(TICK_CYC - 1);

  // Settings hold defaults from reset until software loads new ones
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cfg_r <= odt_pkg::CFG_DEF;
      temp_comp_r <= odt_pkg::CFG_DEF.temp_comp;
    end else if (cfg_wr) begin
      cfg_r <= cfg_in;
      temp_comp_r <= cfg_in.temp_comp;
    end
  end

  // Divider gives one enable pulse per 5 ms
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      div_r <= '0;
      tick_r <= 1'b0;
    end else begin
      div_r <= div_end ? '0 : div_r + 1'b1;
      tick_r <= div_end;
    end
  end

  // ----------------------------------------------------------------
  // Switch delays
  // ----------------------------------------------------------------
  logic [odt_pkg::N_SW-1:0][odt_pkg::N_DLY-1:0] sw_done;
  logic [odt_pkg::N_SW-1:0] sw_nxt;

  genvar s;
  generate
    for (s = 0; s < odt_pkg::N_SW; s++) begin : g_sw
      wire [odt_pkg::N_DLY-1:0] trig = {target_lost,
        !target_lost && sw_off_cond[s], !target_lost && sw_on_cond[s]};
      genvar d;
      for (d = 0; d < odt_pkg::N_DLY; d++) begin : g_dly
        odt_dly u_dly (
          .clk(clk),
          .rst(rst),
          .tick(tick_r),
          .trig(trig[d]),
          .dly(cfg_r.sw_dly[s][d]),
          .done(sw_done[s][d])
        );
      end
      // Lost target outranks distance-driven switching
      assign sw_nxt[s] = sw_done[s][odt_pkg::SW_NT] ? cfg_r.sw_nt_lvl[s] :
        sw_done[s][odt_pkg::SW_ON] ? 1'b1 :
        sw_done[s][odt_pkg::SW_OFF] ? 1'b0 : sw_out_r[s];
    end
  endgenerate

  // Switch state register
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sw_out_r <= '0;
    end else begin
      sw_out_r <= sw_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Analog lost-target delay
  // ----------------------------------------------------------------
  logic ana_done;
  odt_pkg::odt_ana_t loop_nxt;
  odt_pkg::odt_ana_t volt_nxt;

  // One shared timer for all analog outputs
  odt_dly u_ana (
    .clk(clk),
    .rst(rst),
    .tick(tick_r),
    .trig(target_lost),
    .dly(cfg_r.ana_nt_dly),
    .done(ana_done)
  );

  function automatic odt_pkg::odt_ana_t act_map(odt_pkg::odt_nt_act_t a);
    unique case (a)
      odt_pkg::NT_HIGH: act_map = odt_pkg::ANA_HIGH;
      odt_pkg::NT_LOW: act_map = odt_pkg::ANA_LOW;
      default: act_map = odt_pkg::ANA_HOLD;
    endcase
  endfunction

  // Separate action selections for current loop and voltage
  assign loop_nxt = ana_done ? act_map(cfg_r.loop_act) :
    odt_pkg::ANA_TRACK;
  assign volt_nxt = ana_done ? act_map(cfg_r.volt_act) :
    odt_pkg::ANA_TRACK;

  // Analog mode registers
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      loop_mode_r <= odt_pkg::ANA_TRACK;
      volt_mode_r <= odt_pkg::ANA_TRACK;
    end else begin
      loop_mode_r <= loop_nxt;
      volt_mode_r <= volt_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Measurement interval and output update pacing
  // ----------------------------------------------------------------
  logic [odt_pkg::DLY_W-1:0] ivl_r;
  logic [17:0] upd_cnt_r;
  logic [2:0] rg_cnt_r;
  wire ivl_end = tick_r && (ivl_r + 1'b1 >= cfg_r.meas_ivl);
  wire use_m = cfg_r.rej_mode == odt_pkg::REJ_CLOSE ||
    cfg_r.rej_mode == odt_pkg::REJ_FAR;
  wire stab_on = cfg_r.rej_mode == odt_pkg::REJ_STAB;
  wire [17:0] m_fac = use_m ? 18'(cfg_r.sel_m) : odt_pkg::MULT_ONE;
  wire [17:0] n_fac = cfg_r.box_en ? 18'(cfg_r.box_n) : odt_pkg::MULT_ONE;
  wire [35:0] mult_w = m_fac * n_fac;
  wire [17:0] mult = mult_w[17:0];
  wire regained = rg_cnt_r >= cfg_r.stab_y;
  wire gate_ok = !stab_on || (target_stable && regained);
  wire upd_hit = meas_tick_r && gate_ok && (upd_cnt_r + 1'b1 >= mult);

  // Interval counter in 5 ms ticks
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ivl_r <= '0;
      meas_tick_r <= 1'b0;
    end else begin
      if (tick_r) begin
        ivl_r <= ivl_end ? '0 : ivl_r + 1'b1;
      end
      meas_tick_r <= ivl_end;
    end
  end

  // Regain counter: stability must hold for Y intervals before resuming
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rg_cnt_r <= '0;
    end else if (!target_stable) begin
      rg_cnt_r <= '0;
    end else if (meas_tick_r && !regained) begin
      rg_cnt_r <= rg_cnt_r + 1'b1;
    end
  end

  // Update every M*N intervals; a stall keeps the partial count
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      upd_cnt_r <= '0;
      upd_r <= 1'b0;
    end else begin
      if (meas_tick_r && gate_ok) begin
        upd_cnt_r <= upd_hit ? '0 : upd_cnt_r + 1'b1;
      end
      upd_r <= upd_hit;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence lost_expired;
    ana_done ##1 1'b1;
  endsequence

  cfg_load_a: assert property (cfg_wr |=> cfg_r == $past(cfg_in))
    else $error("configuration not loaded");
  // Compare against the loaded word, not the stored copy of it
  temp_comp_a: assert property (
    cfg_wr |=> temp_comp_r == $past(cfg_in.temp_comp))
    else $error("compensation enable mismatch");
  sw_nt_force_a: assert property (
    sw_done[0][odt_pkg::SW_NT] |=>
    sw_out_r[0] == $past(cfg_r.sw_nt_lvl[0]))
    else $error("switch lost-target level not applied");
  sw_on_act_a: assert property (
    sw_done[1][odt_pkg::SW_ON] && !sw_done[1][odt_pkg::SW_NT] |=>
    sw_out_r[1])
    else $error("switch did not turn on after delay");
  ana_force_a: assert property (lost_expired |->
    loop_mode_r == act_map($past(cfg_r.loop_act)) &&
    volt_mode_r == act_map($past(cfg_r.volt_act)))
    else $error("analog lost-target action wrong");
  ana_restart_a: assert property (!target_lost |=> ##1
    loop_mode_r == odt_pkg::ANA_TRACK)
    else $error("analog action held after target return");
  stab_gate_a: assert property (stab_on && !target_stable |=> !upd_r)
    else $error("update while target unstable");
  // The update pulse trails the interval pulse by exactly one cycle
  upd_paced_a: assert property (upd_r |-> $past(meas_tick_r))
    else $error("update not aligned to interval");
  tick_gap_a: assert property (tick_r && TICK_CYC > 1 |=> !tick_r)
    else $error("timebase pulses too close");
endmodule
`default_nettype wire

// ===== logic/odt_pkg.sv
// Shared constants and types for the output delay timers
package odt_pkg;
  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS = 25;
  localparam int unsigned TICK_NS = 5_000_000;
  localparam int unsigned TICK_CYC = TICK_NS / CLK_PERIOD_NS;
  localparam int unsigned TICK_MS = 5;
  localparam int unsigned MAX_DLY_MS = 327_600;
  localparam int unsigned MAX_DLY_TICKS = MAX_DLY_MS / TICK_MS;
  localparam int unsigned DLY_W = 16;
  localparam int unsigned MEAS_MS = 50;
  localparam int unsigned SW_NT_MS = 60_000;
  localparam int unsigned SW_ON = 0;
  localparam int unsigned SW_OFF = 1;
  localparam int unsigned SW_NT = 2;
  localparam int unsigned N_SW = 2;
  localparam int unsigned N_DLY = 3;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [DLY_W-1:0] MEAS_DEF = DLY_W'(MEAS_MS / TICK_MS);
  localparam logic [DLY_W-1:0] SW_NT_DEF = DLY_W'(SW_NT_MS / TICK_MS);
  localparam logic [DLY_W-1:0] DLY_ZERO = 16'h0000;
  localparam logic [9:0] SEL_M_DEF = 10'h002;
  localparam logic [7:0] BOX_N_DEF = 8'h02;
  localparam logic [2:0] STAB_Y_DEF = 3'h2;
  localparam logic [17:0] MULT_ONE = 18'h0_0001;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {NT_HOLD, NT_HIGH, NT_LOW} odt_nt_act_t;
  typedef enum logic [1:0] {ANA_TRACK, ANA_HOLD, ANA_HIGH, ANA_LOW}
    odt_ana_t;
  typedef enum logic [1:0] {REJ_NONE, REJ_CLOSE, REJ_FAR, REJ_STAB}
    odt_rej_t;

  typedef struct packed {
    logic [N_SW-1:0][N_DLY-1:0][DLY_W-1:0] sw_dly;
    logic [N_SW-1:0] sw_nt_lvl;
    logic [DLY_W-1:0] ana_nt_dly;
    odt_nt_act_t loop_act;
    odt_nt_act_t volt_act;
    logic [DLY_W-1:0] meas_ivl;
    odt_rej_t rej_mode;
    logic [9:0] sel_m;
    logic box_en;
    logic [7:0] box_n;
    logic [2:0] stab_y;
    logic temp_comp;
  } odt_cfg_t;

  localparam odt_cfg_t CFG_DEF = '{
    sw_dly: '{'{SW_NT_DEF, DLY_ZERO, DLY_ZERO},
              '{SW_NT_DEF, DLY_ZERO, DLY_ZERO}},
    sw_nt_lvl: 2'b00,
    ana_nt_dly: DLY_ZERO,
    loop_act: NT_HOLD,
    volt_act: NT_HOLD,
    meas_ivl: MEAS_DEF,
    rej_mode: REJ_NONE,
    sel_m: SEL_M_DEF,
    box_en: 1'b0,
    box_n: BOX_N_DEF,
    stab_y: STAB_Y_DEF,
    temp_comp: 1'b1
  };
endpackage

// ===== logic/odt_dly.sv
// Retriggerable delay timer counting 5 ms ticks
`timescale 1ns/10ps
`default_nettype none
module odt_dly (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Timebase and condition
  input wire logic tick,
  input wire logic trig,
  input wire logic [odt_pkg::DLY_W-1:0] dly,
  // Expiry level
  output logic done
);
  // ----------------------------------------------------------------
  // Counter
  // ----------------------------------------------------------------
  logic [odt_pkg::DLY_W-1:0] cnt_r;
  logic [odt_pkg::DLY_W-1:0] cnt_nxt;
  logic done_nxt;
  wire reached = cnt_r >= dly;

  // Losing the condition clears the count; it saturates at the delay
  assign cnt_nxt = !trig ? '0 : (tick && !reached) ? cnt_r + 1'b1 : cnt_r;
  assign done_nxt = trig && reached;

  // Count and expiry flag
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_r <= '0;
      done <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      done <= done_nxt;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  dly_retrig_a: assert property (!trig |=> !done && cnt_r == '0)
    else $error("timer not cleared when condition dropped");
  dly_expire_a: assert property (done |-> $past(trig) && $past(reached))
    else $error("timer expired without full delay");
endmodule
`default_nettype wire

// ===== sim/odt_equip.sv
// Equipment model that watches the switch lines of the sensor
`timescale 1ns/10ps
`default_nettype none
module odt_equip (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Switch lines from the sensor
  input wire logic [1:0] sw_out,
  // Transitions seen
  output var int sw_edges
);
  logic [1:0] last_r;
  // Relays act on settled levels, so sample at the rising edge
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      last_r <= 2'b00;
      sw_edges <= 0;
    end else begin
      last_r <= sw_out;
      sw_edges <= sw_edges + $countones(last_r ^ sw_out);
    end
  end
endmodule
`default_nettype wire

// ===== sim/odt_top_tb_top.sv
// Self-checking bench for the output delay timers
`timescale 1ns/10ps
`default_nettype none
module odt_top_tb_top;
  localparam int TC = 4;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic cfg_wr = 1'b0;
  odt_pkg::odt_cfg_t cfg_in = odt_pkg::CFG_DEF;
  logic [1:0] on_c = 2'b00;
  logic [1:0] off_c = 2'b00;
  logic lost = 1'b0;
  logic stab = 1'b1;
  logic [1:0] sw_out_r;
  odt_pkg::odt_ana_t loop_mode_r;
  odt_pkg::odt_ana_t volt_mode_r;
  logic meas_tick_r;
  logic upd_r;
  logic temp_comp_r;
  odt_pkg::odt_cfg_t cfg_r;
  odt_pkg::odt_cfg_t c;
  int n_fail = 0;
  int num_checks = 0;
  int seed = 32'h0bcd;
  int n_meas;
  int n_upd;
  int d;
  int sw_edges;

  // Clock at 40 MHz
  always #12.5 clk = ~clk;

  odt_top #(.TICK_CYC(TC)) u_dut (.clk(clk), .rst(rst), .cfg_wr(cfg_wr),
    .cfg_in(cfg_in), .sw_on_cond(on_c), .sw_off_cond(off_c),
    .target_lost(lost), .target_stable(stab), .sw_out_r(sw_out_r),
    .loop_mode_r(loop_mode_r), .volt_mode_r(volt_mode_r),
    .meas_tick_r(meas_tick_r), .upd_r(upd_r), .temp_comp_r(temp_comp_r),
    .cfg_r(cfg_r));
  odt_equip u_eq (.clk(clk), .rst(rst), .sw_out(sw_out_r),
    .sw_edges(sw_edges));

  // ----------------------------------------------------------------
  // Reference model and helpers
  // ----------------------------------------------------------------
  // Held cycles needed: D ticks at worst tick phase plus output stages
  function automatic logic exp_sw(input int held, input int dly);
    return held >= dly * TC + 3;
  endfunction
  function automatic odt_pkg::odt_ana_t exp_ana(input int a);
    return a == 1 ? odt_pkg::ANA_HIGH :
           a == 2 ? odt_pkg::ANA_LOW : odt_pkg::ANA_HOLD;
  endfunction
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      n_fail++;
      $display("unexpected %s exp %0h got %0h", nm, e, g);
    end
  endtask
  task automatic chk_cfg(input odt_pkg::odt_cfg_t e);
    num_checks++;
    if (cfg_r !== e) begin
      n_fail++;
      $display("unexpected cfg_r exp %0h got %0h", e, cfg_r);
    end
  endtask
  task automatic tally_and_finish;
    if (n_fail == 0 && num_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask
  // Pulses are one cycle long, so look just after each rising edge
  task automatic count(input int n);
    n_meas = 0;
    n_upd = 0;
    repeat (n) begin
      @(posedge clk);
      #1;
      n_meas += meas_tick_r;
      n_upd += upd_r;
    end
    @(negedge clk);
  endtask
  task automatic load(input odt_pkg::odt_cfg_t v);
    cfg_in = v;
    cfg_wr = 1'b1;
    cyc(1);
    cfg_wr = 1'b0;
    cyc(1);
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    cyc(2);
    rst = 1'b0;
    cyc(1);
    chk("nt_def", 16'h2ee0, cfg_r.sw_dly[0][2]);
    chk("on_def", 16'h0000, cfg_r.sw_dly[1][0]);
    chk("ana_def", 16'h0000, cfg_r.ana_nt_dly);
    chk("tc_def", 1, temp_comp_r);
    count(400);
    chk("meas_def", 1, n_meas >= 9 && n_meas <= 11);
    chk("upd_def", 1, n_upd >= n_meas - 1 && n_upd <= n_meas);
    d = 2 + {$random(seed)} % 3;
    c = odt_pkg::CFG_DEF;
    c.meas_ivl = 16'h0001;
    c.temp_comp = 1'b0;
    c.sw_nt_lvl = 2'b01;
    c.ana_nt_dly = 16'h0002;
    for (int s = 0; s < 2; s++) begin
      c.sw_dly[s] = '{16'h0004, 16'(d), 16'(d)};
    end
    load(c);
    chk_cfg(c);
    chk("tc", 0, temp_comp_r);
    // Each switch: interrupted hold, then full on, then full off
    for (int s = 0; s < 2; s++) begin
      on_c[s] = 1'b1;
      cyc((d - 1) * TC);
      on_c[s] = 1'b0;
      cyc(1);
      on_c[s] = 1'b1;
      cyc((d - 1) * TC);
      chk("sw_short", exp_sw((d - 1) * TC, d), sw_out_r[s]);
      cyc(TC + 3);
      chk("sw_on", exp_sw(d * TC + 3, d), sw_out_r[s]);
      on_c[s] = 1'b0;
      off_c[s] = 1'b1;
      cyc(d * TC + 3);
      chk("sw_off", !exp_sw(d * TC + 3, d), sw_out_r[s]);
      off_c[s] = 1'b0;
    end
    chk("edges", 4, sw_edges);
    lost = 1'b1;
    cyc(4 * TC + 3);
    chk("sw_nt", 2'b01, sw_out_r);
    lost = 1'b0;
    // Every lost-target action, loop and voltage set apart
    for (int a = 0; a < 3; a++) begin
      c.loop_act = odt_pkg::odt_nt_act_t'(a);
      c.volt_act = odt_pkg::odt_nt_act_t'((a + 1) % 3);
      load(c);
      lost = 1'b1;
      cyc(TC);
      lost = 1'b0;
      cyc(1);
      lost = 1'b1;
      cyc(TC);
      chk("ana_rst", odt_pkg::ANA_TRACK, loop_mode_r);
      cyc(TC + 3);
      chk("loop", exp_ana(a), loop_mode_r);
      chk("volt", exp_ana((a + 1) % 3), volt_mode_r);
      lost = 1'b0;
      cyc(3);
      chk("ana_back", odt_pkg::ANA_TRACK, volt_mode_r);
    end
    c.rej_mode = odt_pkg::REJ_CLOSE;
    c.sel_m = 10'h003;
    c.box_en = 1'b1;
    load(c);
    count(240);
    chk("meas", 1, n_meas >= 59 && n_meas <= 61);
    chk("upd_mn", 1, n_upd * 6 >= n_meas - 6 && n_upd * 6 <= n_meas);
    c.rej_mode = odt_pkg::REJ_STAB;
    load(c);
    stab = 1'b0;
    count(100);
    chk("upd_stall", 0, n_upd);
    stab = 1'b1;
    count(200);
    chk("upd_resume", 1, n_upd > 0);
    tally_and_finish;
  end

  // Watchdog well beyond the expected run of about 1100 cycles
  initial begin
    #(25 * 20000);
    n_fail++;
    tally_and_finish;
  end
endmodule
`default_nettype wire
